// *** core/pfr_map.vh ***
/*
  register map, field positions, reset values and timing counts of the power-fail restart
  controller.
  assumes a 50 MHz clock and 32-bit AHB-Lite register words.
*/
`ifndef PFR_MAP_VH
`define PFR_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PFR_CTRL_OFS    8'h00
`define PFR_UVLIM_OFS   8'h04
`define PFR_FREQ_OFS    8'h08
`define PFR_STATUS_OFS  8'h0C
`define PFR_IRQ_OFS     8'h10
`define PFR_MASK_OFS    8'h14
`define PFR_STATE_OFS   8'h18

// ------------------------------------------------------------
// ctrl fields: mode[2:0], overcurrent limit enable bit 3
// ------------------------------------------------------------
`define PFR_CTRL_MODE_LSB 0
`define PFR_CTRL_MODE_MSB 2
`define PFR_CTRL_OCL_BIT  3
`define PFR_CTRL_RST      4'h0

// ------------------------------------------------------------
// frequency register: restart frequency setting in [15:0]
// ------------------------------------------------------------
`define PFR_UVLIM_RST  16'h0000
`define PFR_FSTART_RST 16'h0000

// ------------------------------------------------------------
// event bits of irq and mask
// ------------------------------------------------------------
`define PFR_EV_FAIL    0
`define PFR_EV_RECOVER 1
`define PFR_EV_ALARM   2
`define PFR_EV_RESTART 3
`define PFR_EV_CANCEL  4
`define PFR_EV_W       5

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PFR_CLK_HZ        50000000
`define PFR_HOLD_MS       500
`define PFR_WINDOW_MS     2000
`define PFR_HOLD_CYCLES   (`PFR_CLK_HZ / 1000 * `PFR_HOLD_MS)
`define PFR_WINDOW_CYCLES (`PFR_CLK_HZ / 1000 * `PFR_WINDOW_MS)

`endif

// *** core/pfr_sync.v ***
/*
  two-flop synchroniser for a bundle of asynchronous level inputs.
  assumes the inputs are slow levels; no bus coherency is promised between bits.
*/
`timescale 1ns/1ps
`default_nettype none

module pfr_sync #(
  parameter W = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // pfr_sync

`default_nettype wire

// *** core/pfr_ctrl.v ***
/*
  power-fail restart controller: watches the dc link voltage while running, and per the
  selected restart mode trips, trips on recovery, or restarts at the saved or starting
  frequency, with restart hold-off, run window and coast-stop cancel. registers on ahb-lite.
  assumes run_cmd and coast_stop_command are asynchronous pins; dc_bus_level, out_freq and
  motor_synced come from logic on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pfr_map.vh"

// Behaviour
// - undervoltage while running means power failure
// - mode 0: stop, alarm, coast, no restart
// - mode 1: stop quietly, alarm on recovery
// - mode 4: save frequency, restart there on run
// - mode 4: limiter lowers frequency, then ramp up
// - speed sync only when overcurrent limit enabled
// - mode 5: restart from starting frequency on run
// - hold restart off at least 0.5 s
// - wait 2 s for run after recovery
// - run later than 2 s: starting frequency
// - coast-stop cancels wait; start from starting frequency
module pfr_ctrl #(
  parameter HOLD_CYCLES = `PFR_HOLD_CYCLES,
  parameter WINDOW_CYCLES = `PFR_WINDOW_CYCLES
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire running,
  input wire [15:0] dc_bus_level,
  input wire [15:0] out_freq,
  input wire run_cmd,
  input wire coast_stop_command,
  input wire motor_synced,
  output reg output_enable,
  output reg start_pulse,
  output reg [15:0] start_freq,
  output reg limiter_sync,
  output reg uv_alarm,
  output reg irq
);

  // ------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DIP = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_SYNC = 3'h3;
  localparam [2:0] ST_TRIP = 3'h4;
  localparam [2:0] ST_CANCEL = 3'h5;

  // counts are cut to the 28-bit counters on purpose; the longest window still fits
  localparam [31:0] HOLD_W = HOLD_CYCLES;
  localparam [31:0] WIN_W = WINDOW_CYCLES;
  localparam [27:0] HOLD_N = HOLD_W[27:0];
  localparam [27:0] WIN_N = WIN_W[27:0];

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [3:0] ctrl;
  reg [15:0] uv_limit;
  reg [15:0] fstart;
  reg [`PFR_EV_W-1:0] irq_stat;
  reg [`PFR_EV_W-1:0] irq_mask;
  // one-cycle event pulses, folded into the sticky bits a clock later
  reg [`PFR_EV_W-1:0] ev;
  reg [2:0] state;
  reg [15:0] saved_freq;
  reg [27:0] hold_cnt;
  reg [27:0] win_cnt;
  reg window_open;
  reg late;
  reg d_wr;
  reg d_rd;
  reg [7:0] d_addr;

  wire [1:0] pins_s;
  wire run_s;
  wire bx_s;

  // pins are asynchronous to hclk
  pfr_sync #(.W(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({coast_stop_command, run_cmd}),
    .dout(pins_s)
  );
  assign run_s = pins_s[0];
  assign bx_s = pins_s[1];

  wire [2:0] mode = ctrl[`PFR_CTRL_MODE_MSB:`PFR_CTRL_MODE_LSB];
  wire ocl_en = ctrl[`PFR_CTRL_OCL_BIT];
  wire undervolt = dc_bus_level < uv_limit;
  wire accept = hsel & hready & htrans[1];
  wire hold_done = (hold_cnt == 28'h0000000);

  // ------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_wr <= 1'b0;
      d_rd <= 1'b0;
      d_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // hreadyout and hresp never move after reset: no access stalls or errors
      d_wr <= accept & hwrite;
      d_rd <= accept & ~hwrite;
      if (accept) begin
        d_addr <= haddr[7:0];
      end
    end
  end

  // read data is registered in the address phase so hrdata is a flop output
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (accept & ~hwrite) begin
      case (haddr[7:0])
        `PFR_CTRL_OFS: hrdata <= {28'h0000000, ctrl};
        `PFR_UVLIM_OFS: hrdata <= {16'h0000, uv_limit};
        `PFR_FREQ_OFS: hrdata <= {16'h0000, fstart};
        `PFR_STATUS_OFS: hrdata <= {16'h0000, saved_freq};
        `PFR_IRQ_OFS: hrdata <= {27'h0000000, irq_stat};
        `PFR_MASK_OFS: hrdata <= {27'h0000000, irq_mask};
        `PFR_STATE_OFS: hrdata <= {26'h0000000, late, window_open, uv_alarm, state};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // writable settings; a write to a read-only or unmapped word is dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `PFR_CTRL_RST;
      uv_limit <= `PFR_UVLIM_RST;
      fstart <= `PFR_FSTART_RST;
      irq_mask <= {`PFR_EV_W{1'b0}};
    end else if (d_wr) begin
      case (d_addr)
        `PFR_CTRL_OFS: ctrl <= hwdata[3:0];
        `PFR_UVLIM_OFS: uv_limit <= hwdata[15:0];
        `PFR_FREQ_OFS: fstart <= hwdata[15:0];
        `PFR_MASK_OFS: irq_mask <= hwdata[`PFR_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky events, cleared by a read; a new event in the clearing cycle survives
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= {`PFR_EV_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (d_rd && d_addr == `PFR_IRQ_OFS) begin
        // clear only what the read returned: a bit set at the address edge was not seen yet
        irq_stat <= (irq_stat & ~hrdata[`PFR_EV_W-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // restart sequencer
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      saved_freq <= 16'h0000;
      hold_cnt <= 28'h0000000;
      win_cnt <= 28'h0000000;
      window_open <= 1'b0;
      late <= 1'b0;
      output_enable <= 1'b1;
      start_pulse <= 1'b0;
      start_freq <= 16'h0000;
      limiter_sync <= 1'b0;
      uv_alarm <= 1'b0;
      ev <= {`PFR_EV_W{1'b0}};
    end else begin
      start_pulse <= 1'b0;
      ev <= {`PFR_EV_W{1'b0}};
      if (hold_cnt != 28'h0000000) begin
        hold_cnt <= hold_cnt - 28'h0000001;
      end
      case (state)
        ST_IDLE: begin
          // a new failure is only seen from idle; later dips are handled per state
          if (running && undervolt) begin
            output_enable <= 1'b0; // output stops at once, motor coasts
            saved_freq <= out_freq;
            hold_cnt <= HOLD_N;
            ev[`PFR_EV_FAIL] <= 1'b1;
            if (mode == 3'h0) begin
              uv_alarm <= 1'b1;
              ev[`PFR_EV_ALARM] <= 1'b1;
              state <= ST_TRIP;
            end else begin
              state <= ST_DIP;
            end
          end
        end
        ST_DIP: begin
          // saved frequency and pending restart held here
          if (bx_s) begin
            state <= ST_CANCEL;
            ev[`PFR_EV_CANCEL] <= 1'b1;
          end else if (!undervolt) begin
            ev[`PFR_EV_RECOVER] <= 1'b1;
            if (mode == 3'h1) begin
              uv_alarm <= 1'b1;
              ev[`PFR_EV_ALARM] <= 1'b1;
              state <= ST_TRIP;
            end else if (mode == 3'h4 || mode == 3'h5) begin
              win_cnt <= WIN_N;
              window_open <= 1'b1;
              late <= 1'b0;
              state <= ST_WAIT;
            end else begin
              uv_alarm <= 1'b1; // unsupported mode code trips safely
              ev[`PFR_EV_ALARM] <= 1'b1;
              state <= ST_TRIP;
            end
          end
        end
        ST_WAIT: begin
          if (win_cnt != 28'h0000000) begin
            win_cnt <= win_cnt - 28'h0000001;
          end else begin
            window_open <= 1'b0;
            late <= 1'b1;
          end
          if (bx_s) begin
            window_open <= 1'b0;
            state <= ST_CANCEL;
            ev[`PFR_EV_CANCEL] <= 1'b1;
          end else if (undervolt) begin
            window_open <= 1'b0;
            state <= ST_DIP; // supply dipped again, keep waiting
          end else if (run_s && hold_done) begin
            output_enable <= 1'b1;
            start_pulse <= 1'b1;
            window_open <= 1'b0;
            ev[`PFR_EV_RESTART] <= 1'b1;
            if (mode == 3'h4 && win_cnt != 28'h0000000) begin
              start_freq <= saved_freq;
              limiter_sync <= ocl_en;
              state <= ocl_en ? ST_SYNC : ST_IDLE;
            end else begin
              start_freq <= fstart;
              state <= ST_IDLE;
            end
          end
        end
        ST_SYNC: begin
          // limiter pulls frequency down until motor speed matches, then ramps back
          if (motor_synced || !running) begin
            limiter_sync <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_TRIP: begin
          // only reset leaves the trip state
          output_enable <= 1'b0; // no automatic restart
        end
        ST_CANCEL: begin
          // the flux hold-off applies to a cancelled restart as well
          if (run_s && !undervolt && hold_done) begin
            output_enable <= 1'b1;
            start_pulse <= 1'b1;
            start_freq <= fstart;
            ev[`PFR_EV_RESTART] <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // pfr_ctrl

`default_nettype wire

// *** bench/pfr_props.sv ***
/*
  checker for the restart controller outputs.
  assumes it is bound into pfr_ctrl and gets the same hold count.
*/
`timescale 1ns/1ps
`default_nettype none
module pfr_props #(parameter HOLD_CYCLES = 20) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic output_enable,
  input wire logic start_pulse,
  input wire logic [15:0] start_freq,
  input wire logic uv_alarm
);
  // cycles spent with the output off, to see the hold-off
  logic [31:0] off_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) off_cnt <= 32'h0;
    else if (output_enable) off_cnt <= 32'h0;
    else off_cnt <= off_cnt + 32'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_restart; $rose(output_enable) ##0 start_pulse; endsequence
  sequence s_trip; uv_alarm && !output_enable && !start_pulse; endsequence
  a_pulse_single: assert property (start_pulse |=> !start_pulse) else $error("long pulse");
  a_pulse_enables: assert property (start_pulse |-> s_restart) else $error("pulse w/o on");
  a_rise_has_pulse: assert property ($rose(output_enable) |-> start_pulse) else $error("on");
  a_hold_time: assert property (start_pulse |-> off_cnt >= HOLD_CYCLES - 1) else $error("hold");
  a_off_lasts: assert property ($fell(output_enable) |=> !output_enable [*8]) else $error("off");
  a_freq_kept: assert property ($changed(start_freq) |-> start_pulse) else $error("freq");
  a_alarm_sticky: assert property (uv_alarm |=> uv_alarm) else $error("alarm dropped");
  a_alarm_trips: assert property (uv_alarm |-> s_trip) else $error("alarm with output");
endmodule // pfr_props
bind pfr_ctrl pfr_props #(.HOLD_CYCLES(HOLD_CYCLES)) pfr_props_i (.hclk(hclk), .hresetn(hresetn),
  .output_enable(output_enable), .start_pulse(start_pulse), .start_freq(start_freq),
  .uv_alarm(uv_alarm));
`default_nettype wire

// *** bench/pfr_relays.sv ***
/*
  model of the outside run and coast-stop relays.
  assumes the bench asks for levels; pins change off the clock after a lag.
*/
`timescale 1ns/1ps
`default_nettype none
module pfr_relays (
  input wire logic want_run,
  input wire logic want_coast,
  input wire logic [7:0] lag,
  output var logic run_cmd,
  output var logic coast_stop_command
);
  // relay contacts settle late; lag lets the bench try quick and slow relays
  initial begin
    run_cmd = 1'b0;
    coast_stop_command = 1'b0;
  end
  always @(want_run) run_cmd <= #(lag * 7 + 3) want_run;
  always @(want_coast) coast_stop_command <= #(lag * 7 + 3) want_coast;
endmodule // pfr_relays
`default_nettype wire

// *** bench/tb_top.sv ***
/*
  testbench for the power-fail restart controller.
  assumes short hold (20) and window (50) counts and zero-wait bus answers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pfr_map.vh"
module tb_top;
  localparam int FST = 16'h0030;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, running = 0, motor_synced = 0;
  logic want_run = 0, want_coast = 0, run_cmd, coast_stop_command, start_pulse, limiter_sync;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [15:0] dc_bus_level = 0, out_freq = 0, start_freq;
  logic [7:0] lag = 0;
  logic hreadyout, hresp, output_enable, uv_alarm, irq;
  int err_total = 0, samples_checked = 0;
  int cases [8][4] = '{'{5,0,0,1}, '{4,0,0,1}, '{4,1,0,1}, '{4,0,1,1}, '{4,0,0,0},
    '{0,0,0,1}, '{1,0,0,1}, '{2,0,0,1}};
  always #10 hclk = ~hclk;
  pfr_relays pfr_relays_i (.want_run(want_run), .want_coast(want_coast), .lag(lag),
    .run_cmd(run_cmd), .coast_stop_command(coast_stop_command));
  pfr_ctrl #(.HOLD_CYCLES(20), .WINDOW_CYCLES(50)) pfr_ctrl_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .running(running), .dc_bus_level(dc_bus_level), .out_freq(out_freq), .run_cmd(run_cmd),
    .coast_stop_command(coast_stop_command), .motor_synced(motor_synced),
    .output_enable(output_enable), .start_pulse(start_pulse), .start_freq(start_freq),
    .limiter_sync(limiter_sync), .uv_alarm(uv_alarm), .irq(irq));
  // the limiter reports speed match at random moments
  always @(posedge hclk) motor_synced <= $urandom % 2;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value t=%0t seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask
  // single word transfer; waits on hreadyout in both phases
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk(hresp, 1'b0);
  endtask
  task print_verdict;
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one dip with a given mode, late run, coast-stop during the dip, limiter enable
  task run_case(input int m, input int late, input int cst, input int o);
    int f, e, seen;
    logic [31:0] r;
    logic ls;
    f = 16'h0100 + $urandom % 16'h0E00;
    e = (m == 4 && !late && !cst) ? f : FST;
    seen = 0;
    @(posedge hclk) hresetn <= 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    lag <= $urandom % 8;
    chk(output_enable, 1);
    bus(0, 8'h1C, 0, r); chk(r, 0);
    bus(1, `PFR_CTRL_OFS, m | (o ? 8 : 0), r);
    bus(1, `PFR_UVLIM_OFS, 100, r);
    bus(1, `PFR_FREQ_OFS, FST, r);
    bus(1, `PFR_MASK_OFS, (m == 5) ? 32'h1F : 32'h0, r);
    out_freq <= f; running <= 1; dc_bus_level <= 150 + $urandom % 100;
    repeat (4) @(posedge hclk);
    dc_bus_level <= $urandom % 100; want_coast <= cst;
    @(posedge hclk) out_freq <= f + 1;
    repeat (8) @(negedge hclk);
    chk(output_enable, 0);
    chk(uv_alarm, m == 0);
    @(posedge hclk) dc_bus_level <= 200;
    want_coast <= 0;
    repeat (late ? 60 : 0) @(posedge hclk);
    want_run <= 1;
    for (int i = 0; i < 300 && !seen; i++) begin
      @(negedge hclk);
      seen = start_pulse === 1'b1;
      ls = limiter_sync;
    end
    chk(seen, m >= 4);
    if (m >= 4) chk(start_freq, e);
    if (m >= 4) chk(ls, m == 4 && !late && !cst && o);
    else chk(uv_alarm, 1);
    chk(output_enable, m >= 4);
    bus(0, `PFR_STATUS_OFS, 0, r);
    if (m == 4) chk(r[15:0], f);
    bus(0, `PFR_STATE_OFS, 0, r);
    if (late || m < 4) chk(r, late ? 32'h20 : 32'h0C);
    @(negedge hclk) chk(irq, m == 5);
    bus(0, `PFR_IRQ_OFS, 0, r);
    if (m == 5) chk(r, 32'h0B);
    bus(0, `PFR_IRQ_OFS, 0, r); chk(r, 0);
    want_run <= 0; running <= 0;
    repeat (2) @(negedge hclk);
    chk(limiter_sync, 0);
  endtask
  initial begin
    void'($urandom(71337));
    foreach (cases[k]) run_case(cases[k][0], cases[k][1], cases[k][2], cases[k][3]);
    print_verdict;
  end
  // watchdog well past all cases
  initial begin
    #(20 * 40000);
    err_total++;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
